// ---- verilog/sse_stack_regs.v ----
// Sequencer stack entries six to nine with APB access and entry walker
//
// Operation
// RL1 - Bit 15 one writes, zero reads
// RL2 - Bits 14..9 must match entry address
// RL3 - Flag clear: next entry after conversion
// RL4 - Flag set: back to first entry
// RL5 - Bits 7..4 pick converter B channel
// RL6 - Bits 3..0 pick converter A channel
// RL7 - Entry six resets to 0x4c66
// RL8 - Entry seven resets to 0x4f77
// RL9 - Entry eight resets to 0x5000
// RL10 - Entry nine resets to 0x5200
// RL11 - Pointer starts at first entry
`timescale 1ns/1ns
`default_nettype none
`include "sse_regs.vh"

module sse_stack_regs #(
    parameter ENTRIES = 4
) (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire convDone,
    output wire [3:0] convAChannel,
    output wire [3:0] convBChannel,
    output wire [1:0] stepIndex,
    output wire seqActive
);

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    // Returns {hit, index} for an entry address, zero when not an entry
    function [2:0] entryDecode;
        input [7:0] addr;
        reg [7:0] rel;
        begin
            rel = addr - `SSE_ADDR_STEP6;
            if (addr >= `SSE_ADDR_STEP6 && rel[1:0] == 2'b00 && rel[7:4] == 4'h0) begin
                entryDecode = {1'b1, rel[3:2]};
            end else begin
                entryDecode = 3'b000;
            end
        end
    endfunction

    // Own six-bit address of an entry slot
    function [5:0] ownSelect;
        input [1:0] idx;
        begin
            ownSelect = `SSE_IDX_STEP6 + {4'h0, idx};
        end
    endfunction

    // Reset bits held in storage for each slot
    function [8:0] resetBits;
        input integer idx;
        reg [15:0] full;
        begin
            case (idx)
                0: full = `SSE_RST_STEP6; // see RL7
                1: full = `SSE_RST_STEP7; // see RL8
                2: full = `SSE_RST_STEP8; // see RL9
                default: full = `SSE_RST_STEP9; // see RL10
            endcase
            resetBits = full[8:0];
        end
    endfunction

    wire [2:0] hitNow;
    wire entryHit;
    wire [1:0] entryIdx;
    wire ctrlHit;
    wire statHit;
    wire mapped;
    wire setupPhase;
    wire accessWrite;

    assign hitNow = entryDecode(paddr);
    assign entryHit = hitNow[2];
    assign entryIdx = hitNow[1:0];
    assign ctrlHit = (paddr == `SSE_ADDR_CTRL);
    assign statHit = (paddr == `SSE_ADDR_STAT);
    assign mapped = entryHit | ctrlHit | statHit;
    assign setupPhase = psel & ~penable;
    assign accessWrite = psel & penable & pwrite;

    // Zero wait states, error on unmapped addresses
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------------------
    // Write frame check
    // ------------------------------------------------------------------------

    // Only a write frame naming this entry's own address is stored
    wire frameWrite;
    wire frameSelOk;
    assign frameWrite = pwdata[`SSE_F_DIR]; // see RL1
    assign frameSelOk = (pwdata[`SSE_F_SEL_HI:`SSE_F_SEL_LO] == ownSelect(entryIdx)); // see RL2

    wire entryWrite;
    assign entryWrite = accessWrite & entryHit & frameWrite & frameSelOk;

    // ------------------------------------------------------------------------
    // Stack entries
    // ------------------------------------------------------------------------
    wire [8:0] entryBits [0:ENTRIES-1];

    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi = gi + 1) begin : gEntry
            // Slot number of this entry, cut to the pointer width below
            localparam [31:0] SLOT_FULL = gi;
            sse_entry #(
                .RESET_BITS(resetBits(gi))
            ) uEntry (
                .clk(clk),
                .resetn(resetn),
                .wrEn(entryWrite && (entryIdx == SLOT_FULL[1:0])),
                .wrBits(pwdata[8:0]),
                .entryBits(entryBits[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    reg enable_q;
    reg restart_q;

    // Enable level and a one-cycle restart pulse
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            restart_q <= 1'b0;
            if (accessWrite && ctrlHit) begin
                enable_q <= pwdata[`SSE_CTRL_EN];
                restart_q <= pwdata[`SSE_CTRL_RESTART] |
                    (pwdata[`SSE_CTRL_EN] & ~enable_q);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Conversion-done input sampling
    // ------------------------------------------------------------------------
    reg [`SSE_SYNC_STAGES-1:0] doneSync_q;
    reg doneLevel_q;
    wire doneEdge;

    // Three-stage sampler, stage one feeds stage two only
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doneSync_q <= {`SSE_SYNC_STAGES{1'b0}};
        end else begin
            doneSync_q <= {doneSync_q[`SSE_SYNC_STAGES-2:0], convDone};
        end
    end

    // Level accepted once stages two and three agree
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doneLevel_q <= 1'b0;
        end else if (doneSync_q[1] == doneSync_q[2]) begin
            doneLevel_q <= doneSync_q[2];
        end
    end

    assign doneEdge = (doneSync_q[1] == doneSync_q[2]) & doneSync_q[2] & ~doneLevel_q;

    // ------------------------------------------------------------------------
    // Entry walker
    // ------------------------------------------------------------------------
    reg [1:0] ptr_q;
    reg [1:0] ptr_d;
    reg active_q;
    wire [8:0] curBits;
    wire lastSlot;

    assign curBits = entryBits[ptr_q];
    assign lastSlot = ({30'd0, ptr_q} == ENTRIES - 1);

    // Next pointer after a completed conversion
    always @* begin
        ptr_d = ptr_q;
        if (restart_q) begin
            ptr_d = 2'b00; // see RL11
        end else if (active_q && doneEdge) begin
            if (curBits[`SSE_F_RET] || lastSlot) begin
                ptr_d = 2'b00; // see RL4
            end else begin
                ptr_d = ptr_q + 2'b01; // see RL3
            end
        end
    end

    // Pointer and running state
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_q <= 2'b00; // see RL11
            active_q <= 1'b0;
        end else begin
            ptr_q <= ptr_d;
            active_q <= enable_q;
        end
    end

    // ------------------------------------------------------------------------
    // Channel outputs
    // ------------------------------------------------------------------------
    reg [3:0] chanA_q;
    reg [3:0] chanB_q;

    // Channel picks of the active entry, registered
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chanA_q <= 4'h0;
            chanB_q <= 4'h0;
        end else begin
            chanA_q <= curBits[`SSE_F_A_HI:`SSE_F_A_LO]; // see RL6
            chanB_q <= curBits[`SSE_F_B_HI:`SSE_F_B_LO]; // see RL5
        end
    end

    assign convAChannel = chanA_q;
    assign convBChannel = chanB_q;
    assign stepIndex = ptr_q;
    assign seqActive = active_q;

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    wire [8:0] readBits;

    assign readBits = entryBits[entryIdx];

    // Read word built from the address in the setup cycle
    always @* begin
        rdata_d = 32'h0000_0000;
        if (entryHit) begin
            // Direction reads zero, select field reads the entry address
            rdata_d[`SSE_F_SEL_HI:`SSE_F_SEL_LO] = ownSelect(entryIdx); // see RL2
            rdata_d[8:0] = readBits;
        end else if (ctrlHit) begin
            rdata_d[`SSE_CTRL_EN] = enable_q;
        end else if (statHit) begin
            rdata_d[1:0] = ptr_q;
            rdata_d[2] = active_q;
            rdata_d[3] = doneLevel_q;
        end
    end

    // Captured at setup, held through the access cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;

endmodule
`default_nettype wire

// ---- shared/sse_regs.vh ----
// Register indices, byte addresses, fields and reset values of the stack entries
`ifndef SSE_REGS_VH
`define SSE_REGS_VH

// ----------------------------------------------------------------------------
// Register indices as printed, and byte addresses (index times four)
// ----------------------------------------------------------------------------
`define SSE_IDX_STEP6 6'h26
`define SSE_IDX_STEP7 6'h27
`define SSE_IDX_STEP8 6'h28
`define SSE_IDX_STEP9 6'h29
`define SSE_ADDR_STEP6 8'h98
`define SSE_ADDR_CTRL 8'hb0
`define SSE_ADDR_STAT 8'hb4

// ----------------------------------------------------------------------------
// Entry field positions
// ----------------------------------------------------------------------------
`define SSE_F_DIR 15
`define SSE_F_SEL_HI 14
`define SSE_F_SEL_LO 9
`define SSE_F_RET 8
`define SSE_F_B_HI 7
`define SSE_F_B_LO 4
`define SSE_F_A_HI 3
`define SSE_F_A_LO 0

// ----------------------------------------------------------------------------
// Reset values of the whole entries
// ----------------------------------------------------------------------------
`define SSE_RST_STEP6 16'h4c66
`define SSE_RST_STEP7 16'h4f77
`define SSE_RST_STEP8 16'h5000
`define SSE_RST_STEP9 16'h5200

// ----------------------------------------------------------------------------
// Control fields and sampling
// ----------------------------------------------------------------------------
`define SSE_CTRL_EN 0
`define SSE_CTRL_RESTART 1
`define SSE_SYNC_STAGES 3

`endif

// ---- verilog/sse_entry.v ----
// One stack entry: stored return flag and both channel picks
`timescale 1ns/1ns
`default_nettype none

module sse_entry #(
    parameter [8:0] RESET_BITS = 9'h000
) (
    input wire clk,
    input wire resetn,
    input wire wrEn,
    input wire [8:0] wrBits,
    output wire [8:0] entryBits
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg [8:0] bits_q;

    // Load on accepted write frame, reset to the entry's own default
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bits_q <= RESET_BITS;
        end else if (wrEn) begin
            bits_q <= wrBits;
        end
    end

    assign entryBits = bits_q;

endmodule
`default_nettype wire

// ---- verification/sse_stack_chk.sv ----
// Port checker for the stack entry block
`timescale 1ns/1ns
`default_nettype none
`include "sse_regs.vh"
module sse_stack_chk #(
    parameter ENTRIES = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic convDone,
    input wire logic [3:0] convAChannel,
    input wire logic [3:0] convBChannel,
    input wire logic [1:0] stepIndex,
    input wire logic seqActive
);
    // ------------------------------------------------------------
    // Bus and walker properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Access phase and decoded map
    wire logic acc = psel && penable;
    wire logic mapped = paddr inside {8'h98, 8'h9c, 8'ha0, 8'ha4, 8'hb0, 8'hb4};
    wire logic rd6 = acc && !pwrite && paddr == `SSE_ADDR_STEP6;
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err;
        acc && !mapped |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no error on hole");
    property p_ok;
        acc && mapped |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("error on entry");
    property p_rd6;
        rd6 |-> prdata[15:9] == {1'b0, `SSE_IDX_STEP6};
    endproperty
    a_rd6: assert property (p_rd6) else $error("bad read head");
    property p_hi;
        acc && !pwrite && mapped |-> prdata[31:16] == 16'h0000;
    endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_step;
        $changed(stepIndex) |-> stepIndex == 2'd0 || stepIndex == $past(stepIndex) + 2'd1;
    endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_start;
        $rose(resetn) |-> stepIndex == 2'd0 ##1 stepIndex == 2'd0;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_idle;
        !seqActive && !$past(seqActive) |-> $stable(stepIndex) || stepIndex == 2'd0;
    endproperty
    a_idle: assert property (p_idle) else $error("moved idle");
    // Main scenarios reached
    c_walk: cover property ($changed(stepIndex));
    c_wrap: cover property ($past(stepIndex) == 2'd3 && stepIndex == 2'd0);
    c_hole: cover property (acc && pslverr);
endmodule
`default_nettype wire

// ---- verification/sse_host.sv ----
// Host model: APB master programming the entries
`timescale 1ns/1ns
`default_nettype none
module sse_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rdata;
    logic err;
    // Idle bus at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // One transfer, held until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // Entry write: direction bit set, own select field
    task wr_entry(input logic [7:0] a, input logic [5:0] idx, input logic [8:0] b);
        xfer(1'b1, a, {16'h0, 1'b1, idx, b});
    endtask
endmodule
`default_nettype wire

// ---- verification/test_sse_stack_regs.sv ----
// Self-checking bench for the stack entries and walker
`timescale 1ns/1ns
`default_nettype none
`include "sse_regs.vh"
module test_sse_stack_regs;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [15:0] e;} sse_row_t;
    logic clk;
    logic resetn;
    logic convDone;
    wire psel, penable, pwrite, pready, pslverr, seqActive;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0] convAChannel, convBChannel;
    wire [1:0] stepIndex;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    sse_row_t rows [4] = '{'{8'h98, 32'h0000cd21, 16'h4d21}, '{8'h9c, 32'h00004e12, 16'h4f77},
        '{8'ha0, 32'h0000cc53, 16'h5000}, '{8'ha4, 32'hffffd2a5, 16'h52a5}};
    logic [7:0] ra [4] = '{8'h98, 8'h9c, 8'ha0, 8'ha4};
    logic [15:0] rv [4] = '{`SSE_RST_STEP6, `SSE_RST_STEP7, `SSE_RST_STEP8, `SSE_RST_STEP9};
    logic [9:0] walk [4] = '{10'h177, 10'h293, 10'h34c, 10'h066};
    sse_stack_regs sse_stack_regs_i (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .convDone(convDone),
        .convAChannel(convAChannel), .convBChannel(convBChannel),
        .stepIndex(stepIndex), .seqActive(seqActive));
    sse_host sse_host_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Compare and count
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One conversion done pulse, then settle
    task pulse;
        @(posedge clk);
        convDone <= 1'b1;
        repeat (4) @(posedge clk);
        convDone <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        resetn = 1'b0;
        convDone = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            sse_host_i.xfer(1'b1, rows[i].a, rows[i].d);
            sse_host_i.xfer(1'b0, rows[i].a, 32'h0);
            check("entry", sse_host_i.rdata, {16'h0, rows[i].e});
        end
        $display("test rows done");
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("pick", {stepIndex, convAChannel, convBChannel}, 10'h066);
        foreach (ra[i]) begin
            sse_host_i.xfer(1'b0, ra[i], 32'h0);
            check("reset", sse_host_i.rdata, {16'h0, rv[i]});
        end
        sse_host_i.xfer(1'b0, 8'hc0, 32'h0);
        check("hole error", sse_host_i.err, 1'b1);
        check("hole data", sse_host_i.rdata, 32'h0);
        $display("test reset done");
        pulse();
        check("idle", stepIndex, 2'd0);
        sse_host_i.xfer(1'b1, `SSE_ADDR_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check("active", seqActive, 1'b1);
        pulse();
        check("step", {stepIndex, convAChannel, convBChannel}, 10'h177);
        pulse();
        check("back", {stepIndex, convAChannel, convBChannel}, 10'h066);
        sse_host_i.wr_entry(8'h9c, 6'h27, 9'h077);
        sse_host_i.wr_entry(8'ha0, 6'h28, 9'h039);
        sse_host_i.wr_entry(8'ha4, 6'h29, 9'h0c4);
        foreach (walk[i]) begin
            pulse();
            check("walk", {stepIndex, convAChannel, convBChannel}, walk[i]);
        end
        $display("test walk done");
        // Status word, then restart from slot one back to slot zero
        pulse();
        sse_host_i.xfer(1'b0, `SSE_ADDR_STAT, 32'h0);
        check("status", sse_host_i.rdata, 32'h5);
        sse_host_i.xfer(1'b1, `SSE_ADDR_CTRL, 32'h3);
        sse_host_i.xfer(1'b0, `SSE_ADDR_CTRL, 32'h0);
        check("control", sse_host_i.rdata, 32'h1);
        check("restart", stepIndex, 2'd0);
        $display("test control done");
        give_verdict();
    end
endmodule
bind sse_stack_regs sse_stack_chk #(.ENTRIES(ENTRIES)) sse_stack_chk_i (.clk(clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convDone(convDone), .convAChannel(convAChannel), .convBChannel(convBChannel),
    .stepIndex(stepIndex), .seqActive(seqActive));
`default_nettype wire
